// ### design/atw_pkg.sv
// Package for the analogue threshold, amplifier and watchdog blocks
`default_nettype none
package atw_pkg;
    // ------------------------------------------------------------
    // Value ranges
    // ------------------------------------------------------------
    localparam int AIN_FULL_SCALE = 1000;
    localparam int GAIN_LIMIT     = 1000;   // 10.00 in hundredths
    localparam int GAIN_FRAC_DIV  = 100;
    localparam int OFFSET_LIMIT   = 10000;
    localparam int DELTA_LIMIT    = 20000;
    localparam int BAND_LIMIT     = 20000;
    localparam int AOUT_MAX       = 32767;
    localparam int AOUT_MIN       = -32768;
    localparam int DEC_MAX        = 3;

    // Scaling parameters shared by every block
    typedef struct packed {
        logic signed [15:0] gain;    // Hundredths
        logic signed [15:0] offset;
    } atw_scale_s;

    // Threshold source selection
    typedef struct packed {
        logic               on_ext;
        logic               off_ext;
        logic signed [15:0] on_par;
        logic signed [15:0] off_par;
    } atw_thr_s;

    // Watchdog band settings
    typedef struct packed {
        logic               split_band;
        logic signed [15:0] delta;
        logic        [15:0] band_hi;
        logic        [15:0] band_lo;
    } atw_band_s;

    typedef enum logic [0:0] {
        ATW_WD_IDLE,
        ATW_WD_WATCH
    } atw_wd_e;
endpackage
`default_nettype wire

// ### design/atw_top.sv
// Threshold trigger, amplifier and watchdog evaluated per controller cycle
`default_nettype none
module atw_top
    import atw_pkg::*;
(
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 resetn,
    // Evaluation strobe
    input  wire logic                 eval_en,
    // Threshold trigger
    input  wire logic        [15:0]   trig_analog_in,
    input  wire atw_pkg::atw_scale_s  trig_scale,
    input  wire atw_pkg::atw_thr_s    trig_thr,
    input  wire logic signed [15:0]   trig_on_ext,
    input  wire logic signed [15:0]   trig_off_ext,
    input  wire logic        [1:0]    trig_decimals,
    output logic                      trig_q,
    // Amplifier
    input  wire logic        [15:0]   amp_analog_in,
    input  wire atw_pkg::atw_scale_s  amp_scale,
    output logic signed [15:0]        amp_analog_out,
    // Watchdog
    input  wire logic        [15:0]   wd_analog_in,
    input  wire atw_pkg::atw_scale_s  wd_scale,
    input  wire atw_pkg::atw_band_s   wd_band,
    input  wire logic                 wd_enable,
    output logic                      wd_q,
    output logic signed [15:0]        wd_reference
);
    import atw_pkg::*;

    // ------------------------------------------------------------
    // Parameter clamping and scaling
    // ------------------------------------------------------------
    function automatic logic signed [31:0] clamp(input logic signed [31:0] v, input int lim);
        logic signed [31:0] l;
        l = 32'(lim);
        if (v > l) return l;
        if (v < -l) return -l;
        return v;
    endfunction

    // Input clamped to span, gain in hundredths; result truncates toward zero
    function automatic logic signed [31:0] scale(input logic [15:0] ain, input atw_scale_s s);
        logic signed [31:0] a;
        logic signed [31:0] p;
        a = (ain > 16'(AIN_FULL_SCALE)) ? 32'(AIN_FULL_SCALE) : 32'(signed'({1'b0, ain}));
        p = a * clamp(32'(s.gain), GAIN_LIMIT);
        return p / 32'(GAIN_FRAC_DIV) + clamp(32'(s.offset), OFFSET_LIMIT);
    endfunction

    // ------------------------------------------------------------
    // Threshold trigger
    // ------------------------------------------------------------
    logic signed [31:0] trig_val;
    logic signed [31:0] thr_on;
    logic signed [31:0] thr_off;
    logic               trig_q_r;
    logic               trig_q_nxt;

    always_comb begin
        trig_val = scale(trig_analog_in, trig_scale);
        // Decimals are display-only and never enter the compare
        thr_on  = 32'(trig_thr.on_ext ? trig_on_ext : trig_thr.on_par);
        thr_off = 32'(trig_thr.off_ext ? trig_off_ext : trig_thr.off_par);
        trig_q_nxt = trig_q_r;
        if (eval_en) begin
            if (thr_on >= thr_off) begin
                if (trig_val > thr_on) trig_q_nxt = 1'b1;
                else if (trig_val <= thr_off) trig_q_nxt = 1'b0;
            end else begin
                trig_q_nxt = (trig_val >= thr_on) && (trig_val < thr_off);
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) trig_q_r <= 1'b0;
        else trig_q_r <= trig_q_nxt;
    end
    assign trig_q = trig_q_r;

    // ------------------------------------------------------------
    // Amplifier
    // ------------------------------------------------------------
    logic signed [31:0] amp_val;
    logic signed [15:0] amp_r;
    logic signed [15:0] amp_nxt;

    always_comb begin
        amp_val = scale(amp_analog_in, amp_scale);
        amp_nxt = amp_r;
        if (eval_en) begin
            // Saturate so a big gain never flips the sign
            if (amp_val > 32'(AOUT_MAX)) amp_nxt = 16'(AOUT_MAX);
            else if (amp_val < 32'(AOUT_MIN)) amp_nxt = 16'(AOUT_MIN);
            else amp_nxt = amp_val[15:0];
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) amp_r <= '0;
        else amp_r <= amp_nxt;
    end
    assign amp_analog_out = amp_r;

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    logic signed [31:0] wd_val;
    logic signed [31:0] band_up;
    logic signed [31:0] band_dn;
    logic signed [31:0] dlt;
    logic               wd_en_d_r;
    logic               wd_en_d_nxt;
    atw_wd_e            wd_st_r;
    atw_wd_e            wd_st_nxt;
    logic signed [15:0] ref_r;
    logic signed [15:0] ref_nxt;
    logic               wd_q_r;
    logic               wd_q_nxt;

    always_comb begin
        wd_val = scale(wd_analog_in, wd_scale);
        dlt = clamp(32'(wd_band.delta), DELTA_LIMIT);
        if (dlt < 0) dlt = -dlt;
        if (wd_band.split_band) begin
            band_up = (32'(wd_band.band_hi) > 32'(BAND_LIMIT)) ? 32'(BAND_LIMIT) : 32'(wd_band.band_hi);
            band_dn = (32'(wd_band.band_lo) > 32'(BAND_LIMIT)) ? 32'(BAND_LIMIT) : 32'(wd_band.band_lo);
        end else begin
            band_up = dlt;
            band_dn = dlt;
        end
        wd_en_d_nxt = wd_en_d_r;
        wd_st_nxt   = wd_st_r;
        ref_nxt     = ref_r;
        wd_q_nxt    = wd_q_r;
        if (!wd_enable) begin
            // Forget the old level too, so a rise between strobes still arms
            wd_en_d_nxt = 1'b0;
            wd_st_nxt   = ATW_WD_IDLE;
            wd_q_nxt    = 1'b0;
        end
        if (eval_en) begin
            wd_en_d_nxt = wd_enable;
            case (wd_st_r)
                ATW_WD_IDLE: begin
                    if (wd_enable && !wd_en_d_r) begin
                        // Reference kept scaled, saturated to 16 bits
                        if (wd_val > 32'(AOUT_MAX)) ref_nxt = 16'(AOUT_MAX);
                        else if (wd_val < 32'(AOUT_MIN)) ref_nxt = 16'(AOUT_MIN);
                        else ref_nxt = wd_val[15:0];
                        wd_st_nxt = ATW_WD_WATCH;
                        wd_q_nxt  = 1'b0;
                    end
                end
                ATW_WD_WATCH: begin
                    if (wd_enable) begin
                        wd_q_nxt = (wd_val > 32'(ref_r) + band_up) || (wd_val < 32'(ref_r) - band_dn);
                    end
                end
                default: wd_st_nxt = ATW_WD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wd_en_d_r <= 1'b0;
            wd_st_r   <= ATW_WD_IDLE;
            ref_r     <= '0;
            wd_q_r    <= 1'b0;
        end else begin
            wd_en_d_r <= wd_en_d_nxt;
            wd_st_r   <= wd_st_nxt;
            ref_r     <= ref_nxt;
            wd_q_r    <= wd_q_nxt;
        end
    end
    assign wd_q = wd_q_r;
    assign wd_reference = ref_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Arming is two steps: the enable edge, then a quiet first watch cycle
    sequence s_wd_arm_edge;
        eval_en && wd_enable && !wd_en_d_r && wd_st_r == ATW_WD_IDLE;
    endsequence
    sequence s_wd_armed_quiet;
        !wd_q && wd_st_r == ATW_WD_WATCH;
    endsequence

    a_wd_off_low: assert property (@(posedge clock) disable iff (!resetn)
        !wd_enable |=> !wd_q) else $error("watchdog high after enable low");
    a_wd_needs_en: assert property (@(posedge clock) disable iff (!resetn)
        wd_q |-> wd_st_r == ATW_WD_WATCH) else $error("watchdog high while idle");
    a_wd_arm_quiet: assert property (@(posedge clock) disable iff (!resetn)
        s_wd_arm_edge |=> s_wd_armed_quiet) else $error("watchdog not armed quietly");
    a_amp_hold: assert property (@(posedge clock) disable iff (!resetn)
        !eval_en |=> $stable(amp_analog_out)) else $error("amplifier moved without eval");
    // Limits on input, gain and offset keep this unreachable; it guards later widening
    a_amp_sat: assert property (@(posedge clock) disable iff (!resetn)
        eval_en && amp_val > 32'(AOUT_MAX) |=> amp_analog_out == 16'(AOUT_MAX))
        else $error("amplifier did not saturate");
    a_trig_window: assert property (@(posedge clock) disable iff (!resetn)
        eval_en && thr_on < thr_off && trig_val >= thr_off |=> !trig_q) else $error("window case high");
    a_trig_set: assert property (@(posedge clock) disable iff (!resetn)
        eval_en && thr_on >= thr_off && trig_val > thr_on |=> trig_q) else $error("trigger not set");
    a_trig_hold: assert property (@(posedge clock) disable iff (!resetn)
        eval_en && thr_on >= thr_off && trig_val > thr_off && trig_val <= thr_on |=> $stable(trig_q))
        else $error("trigger left hysteresis hold");
    a_ref_capture: assert property (@(posedge clock) disable iff (!resetn)
        eval_en && wd_enable && !wd_en_d_r && wd_st_r == ATW_WD_IDLE
        && wd_val <= 32'(AOUT_MAX) && wd_val >= 32'(AOUT_MIN)
        |=> wd_reference == $past(wd_val[15:0])) else $error("reference not captured");
endmodule
`default_nettype wire

// ### testbench/atw_chan_model.sv
// Model of the analogue channels and neighbouring blocks that feed the design
`default_nettype none
module atw_chan_model
    import atw_pkg::*;
(
    // Channel values
    output var logic        [15:0] ch_trig,
    output var logic        [15:0] ch_amp,
    output var logic        [15:0] ch_wd,
    // Neighbour block outputs used as thresholds
    output var logic signed [15:0] ext_on,
    output var logic signed [15:0] ext_off
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ch_trig = 16'h0000;
        ch_amp  = 16'h0000;
        ch_wd   = 16'h0000;
        ext_on  = 16'sh0000;
        ext_off = 16'sh0000;
    end
    // Channel span tops out at full scale; larger requests are pinned
    task automatic put(input int ch, input int v);
        logic [15:0] c;
        c = 16'((v > AIN_FULL_SCALE) ? AIN_FULL_SCALE : v);
        if (ch == 0) ch_trig = c;
        else if (ch == 1) ch_amp = c;
        else ch_wd = c;
    endtask
    task automatic put_thr(input int on, input int off);
        ext_on  = 16'(on);
        ext_off = 16'(off);
    endtask
endmodule
`default_nettype wire

// ### testbench/tb_atw_top.sv
// Self-checking bench for the threshold, amplifier and watchdog blocks
`default_nettype none
module tb_atw_top;
    import atw_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic eval_en = 1'b0;
    logic wd_enable = 1'b0;
    logic [1:0] dec = 2'h0;
    atw_scale_s trig_scale, amp_scale, wd_scale;
    atw_thr_s thr;
    atw_band_s band;
    wire logic [15:0] ain_t, ain_a, ain_w;
    wire logic signed [15:0] on_x, off_x;
    logic trig_q, wd_q;
    logic signed [15:0] amp_out, wd_ref;
    int mismatches = 0;
    int comparisons = 0;

    atw_chan_model u_atw_chan_model (.ch_trig(ain_t), .ch_amp(ain_a), .ch_wd(ain_w),
        .ext_on(on_x), .ext_off(off_x));
    atw_top u_atw_top (.clock(clock), .resetn(resetn), .eval_en(eval_en), .trig_analog_in(ain_t),
        .trig_scale(trig_scale), .trig_thr(thr), .trig_on_ext(on_x), .trig_off_ext(off_x),
        .trig_decimals(dec), .trig_q(trig_q), .amp_analog_in(ain_a), .amp_scale(amp_scale),
        .amp_analog_out(amp_out), .wd_analog_in(ain_w), .wd_scale(wd_scale), .wd_band(band),
        .wd_enable(wd_enable), .wd_q(wd_q), .wd_reference(wd_ref));

    always #2.5 clock = ~clock;

    function automatic atw_scale_s sc(input int g, input int o);
        return '{gain: 16'(g), offset: 16'(o)};
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %0d seen %0d", what, $signed(exp), $signed(seen));
        end
    endtask
    // Inputs set at a falling edge, taken at the rising one, read at the next fall
    task automatic step;
        @(posedge clock);
        @(negedge clock);
    endtask
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic t_amp;
        int g[5] = '{1000, -1000, -250, 15, -15};
        int o[5] = '{10000, -10000, -100, 0, 0};
        int a[5] = '{1000, 1000, 500, 7, 7};
        for (int i = 0; i < 5; i++) begin
            amp_scale = sc(g[i], o[i]);
            u_atw_chan_model.put(1, a[i]);
            step();
            chk("amp_analog_out", amp_out, a[i] * g[i] / 100 + o[i]);
        end
        // Without the strobe the output must stand
        eval_en = 1'b0;
        u_atw_chan_model.put(1, 900);
        step();
        chk("amp_hold", amp_out, -1);
        eval_en = 1'b1;
    endtask

    task automatic t_trigger;
        int ins[11] = '{500, 501, 300, 200, 200, 499, 500, 199, 400, 401, 600};
        int exp[11] = '{0, 1, 1, 0, 1, 1, 0, 0, 1, 1, 0};
        trig_scale = sc(100, 0);
        u_atw_chan_model.put_thr(399, 100);
        for (int i = 0; i < 11; i++) begin
            if (i < 4) thr = '{1'b0, 1'b0, 16'sh01f4, 16'sh00c8};
            else if (i < 8) thr = '{1'b0, 1'b0, 16'sh00c8, 16'sh01f4};
            else thr = '{1'b1, 1'b1, 16'sh0000, 16'sh0000};
            if (i == 8) trig_scale = sc(-150, 1000);
            dec = 2'(i);
            u_atw_chan_model.put(0, ins[i]);
            step();
            chk("trig_q", trig_q, exp[i]);
        end
    endtask

    task automatic t_watch;
        int ins[13] = '{400, 400, 450, 451, 349, 350, 100, 100, 106, 105, 84, 85, 84};
        int en[13]  = '{0, 1, 1, 1, 1, 1, 0, 1, 1, 1, 1, 1, 1};
        int exp[13] = '{0, 0, 0, 1, 1, 0, 0, 0, 1, 0, 1, 0, 1};
        wd_scale = sc(100, 0);
        band = '{1'b0, -16'sh0032, 16'h0000, 16'h0000};
        for (int i = 0; i < 13; i++) begin
            if (i == 6) begin
                wd_scale = sc(200, -100);
                band = '{1'b1, 16'sh0000, 16'h000a, 16'h001e};
            end
            wd_enable = en[i][0];
            u_atw_chan_model.put(2, ins[i]);
            step();
            chk("wd_q", wd_q, exp[i]);
            if (i == 1 || i == 7) chk("wd_reference", wd_ref, (i == 1) ? 400 : 100);
        end
        // Dropping enable clears at once, strobe or not
        eval_en = 1'b0;
        wd_enable = 1'b0;
        step();
        chk("wd_q_drop", wd_q, 0);
        eval_en = 1'b1;
    endtask

    task automatic t_reset;
        // Load every output non-zero first so the clear can be seen
        wd_enable = 1'b1;
        u_atw_chan_model.put(0, 0);
        u_atw_chan_model.put(2, 900);
        step();
        u_atw_chan_model.put(2, 0);
        step();
        chk("trig_pre", trig_q, 1);
        chk("ref_pre", wd_ref, 1700);
        chk("wd_pre", wd_q, 1);
        chk("amp_pre", amp_out, -135);
        resetn = 1'b0;
        #1;
        chk("amp_reset", amp_out, 0);
        chk("ref_reset", wd_ref, 0);
        chk("trig_reset", trig_q, 0);
        chk("wd_reset", wd_q, 0);
        @(negedge clock);
        resetn = 1'b1;
    endtask

    initial begin
        trig_scale = sc(0, 0);
        amp_scale = sc(0, 0);
        wd_scale = sc(0, 0);
        thr = '0;
        band = '0;
        repeat (4) @(negedge clock);
        resetn = 1'b1;
        eval_en = 1'b1;
        t_amp();
        t_trigger();
        t_watch();
        t_reset();
        final_report();
    end
    // Whole run is well under a few hundred cycles
    initial begin
        #20000;
        mismatches++;
        final_report();
    end
endmodule
`default_nettype wire
